/* rtl/adc_cal_defines.vh */
// Constants for the calibration access and window comparator block
// Overview of operation
// - Offset coefficient is 14-bit unsigned; 0x2000 means no offset change.
// - Gain coefficient is 13-bit unsigned; 0x1000 means unchanged slope.
// - Pointer location field picks the coefficient byte reached by data reg.
// - Auto-increment bit set bumps location after each data read or write.
// - Converter-select bit picks converter 0 or converter 1 coefficients.
// - Data register reads selected byte from the coefficient store, which reset does not load; write replaces it.
// - Every converter-0 result is compared to limits; hit sets window flag.
// - Window flag serves as interrupt source or polled status bit.
// - Single-ended mode compares result and limits as unsigned words.
// - Differential mode compares as two's complement, 0xffff is minus one.
// - Less-than above greater-than: flag set only strictly inside window.
// - Less-than below greater-than: flag set strictly outside window.
// - Linearity 0x00-0x12, offset 0x13-0x14, gain 0x15-0x16 per converter.
// - Calibration start bit is cleared by device when calibration finishes.
`ifndef ADC_CAL_DEFINES_VH
`define ADC_CAL_DEFINES_VH

// Register addresses
`define ADDR_CAL_POINTER 8'hba
`define ADDR_CAL_DATA 8'hbb
`define ADDR_WIN_LT_HIGH 8'hc7
`define ADDR_WIN_LT_LOW 8'hc6
`define ADDR_WIN_GT_HIGH 8'hc5
`define ADDR_WIN_GT_LOW 8'hc4
`define ADDR_CONV0_CTRL 8'he8
`define ADDR_CAL_START 8'hbc

// Pointer fields and reset
`define PTR_POINTER_AUTO_INCREMENT_BIT 7
`define PTR_SEL_BIT 6
`define PTR_LOC_MSB 5
`define PTR_RESET 8'hd7

// Control register fields
`define CTRL_WIN_FLAG_BIT 5
`define CTRL_DIFF_BIT 0
`define CTRL_RESET 8'h00
`define LIMIT_RESET 8'h00

// Coefficient map
`define LOC_LIN_LAST 6'h12
`define LOC_OFFSET_LO 6'h13
`define LOC_OFFSET_HI 6'h14
`define LOC_GAIN_LO 6'h15
`define LOC_GAIN_HI 6'h16
`define COEF_DEPTH 23
`define OFFSET_MID 14'h2000
`define GAIN_MID 13'h1000
`define COEF_LO_RESET 8'h00
`define OFFSET_HI_RESET 6'h20
`define GAIN_HI_RESET 5'h10
`define START_RESET 2'h0

`endif

/* rtl/coef_memory.v */
// Two-bank coefficient byte store with registered read data
module coef_memory (
    // Clock
    input wire core_clk,
    // Write port
    input wire wr_en,
    input wire [6:0] wr_addr,
    input wire [7:0] wr_data,
    // Read port
    input wire [6:0] rd_addr,
    output reg [7:0] rd_data
);
    reg [7:0] mem [0:127];

    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

/* rtl/adc_cal_window.v */
// Calibration coefficient access and converter-0 window comparator
`include "adc_cal_defines.vh"
module adc_cal_window (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Special function register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    // Converter 0 result
    input wire conv0_done,
    input wire [15:0] conv0_result,
    // Calibration engine
    input wire [1:0] cal_finished,
    output reg [1:0] cal_start_out,
    output reg [13:0] conv0_offset,
    output reg [12:0] conv0_gain,
    output reg [13:0] conv1_offset,
    output reg [12:0] conv1_gain,
    // Window event
    output reg window_hit_flag
);
    // Software visible registers
    reg [7:0] calibration_pointer_reg;
    reg [7:0] calibration_pointer_next;
    reg [7:0] window_greater_than_high_reg;
    reg [7:0] window_greater_than_low_reg;
    reg [7:0] window_less_than_high_reg;
    reg [7:0] window_less_than_low_reg;
    reg [7:0] converter0_control_reg;
    reg [7:0] converter0_control_next;
    reg [1:0] cal_start_next;

    // Read path
    reg rd_data_pending_reg;
    reg [7:0] rdata_next;

    // Window comparator
    reg [15:0] gt_word;
    reg [15:0] lt_word;
    reg [16:0] res_k;
    reg [16:0] gt_k;
    reg [16:0] lt_k;
    reg above_gt;
    reg below_lt;
    reg hit;

    // Decoded strobes and coefficient paths
    wire ptr_wr;
    wire data_wr;
    wire data_rd;
    wire ctrl_wr;
    wire start_wr;
    wire coef_access;
    wire loc_valid;
    wire [6:0] mem_addr;
    wire [7:0] mem_rdata;
    wire [1:0] bank_sel;
    wire [27:0] offset_flat;
    wire [25:0] gain_flat;
    wire diff_mode;
    wire [5:0] loc;

    assign diff_mode = converter0_control_reg[`CTRL_DIFF_BIT];
    assign loc = calibration_pointer_reg[`PTR_LOC_MSB:0];
    assign ptr_wr = sfr_wr && (sfr_addr == `ADDR_CAL_POINTER);
    assign data_wr = sfr_wr && (sfr_addr == `ADDR_CAL_DATA);
    assign data_rd = sfr_rd && (sfr_addr == `ADDR_CAL_DATA);
    assign ctrl_wr = sfr_wr && (sfr_addr == `ADDR_CONV0_CTRL);
    assign start_wr = sfr_wr && (sfr_addr == `ADDR_CAL_START);
    assign coef_access = data_wr || data_rd;

    // Only the documented locations are stored; others read as zero
    assign loc_valid = (loc <= `LOC_GAIN_HI);

    // Converter select forms the bank bit of the store
    assign mem_addr = {calibration_pointer_reg[`PTR_SEL_BIT], loc};
    assign bank_sel = {calibration_pointer_reg[`PTR_SEL_BIT],
                       ~calibration_pointer_reg[`PTR_SEL_BIT]};

    coef_memory coef_memory_inst (
        .core_clk(core_clk),
        .wr_en(data_wr && loc_valid),
        .wr_addr(mem_addr),
        .wr_data(sfr_wdata),
        .rd_addr(mem_addr),
        .rd_data(mem_rdata)
    );

    // Offset and gain bytes also live in flops so they can drive ports
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : conv_coef
            reg [7:0] offset_lo_reg;
            reg [5:0] offset_hi_reg;
            reg [7:0] gain_lo_reg;
            reg [4:0] gain_hi_reg;

            always @(posedge core_clk) begin
                if (!rst_n) begin
                    offset_lo_reg <= `COEF_LO_RESET;
                    offset_hi_reg <= `OFFSET_HI_RESET;
                    gain_lo_reg <= `COEF_LO_RESET;
                    gain_hi_reg <= `GAIN_HI_RESET;
                end else if (data_wr && bank_sel[c]) begin
                    if (loc == `LOC_OFFSET_LO) begin
                        offset_lo_reg <= sfr_wdata;
                    end else if (loc == `LOC_OFFSET_HI) begin
                        offset_hi_reg <= sfr_wdata[5:0];
                    end else if (loc == `LOC_GAIN_LO) begin
                        gain_lo_reg <= sfr_wdata;
                    end else if (loc == `LOC_GAIN_HI) begin
                        gain_hi_reg <= sfr_wdata[4:0];
                    end
                end
            end

            assign offset_flat[c*14 +: 14] = {offset_hi_reg, offset_lo_reg};
            assign gain_flat[c*13 +: 13] = {gain_hi_reg, gain_lo_reg};
        end
    endgenerate

    // Coefficient codes leave the block as plain unsigned words
    always @(posedge core_clk) begin
        if (!rst_n) begin
            conv0_offset <= `OFFSET_MID;
            conv1_offset <= `OFFSET_MID;
            conv0_gain <= `GAIN_MID;
            conv1_gain <= `GAIN_MID;
        end else begin
            conv0_offset <= offset_flat[13:0];
            conv1_offset <= offset_flat[27:14];
            conv0_gain <= gain_flat[12:0];
            conv1_gain <= gain_flat[25:13];
        end
    end

    // Pointer update, auto-increment after each data access
    always @* begin
        calibration_pointer_next = calibration_pointer_reg;
        if (ptr_wr) begin
            calibration_pointer_next = sfr_wdata;
        end else if (coef_access &&
                     calibration_pointer_reg[`PTR_POINTER_AUTO_INCREMENT_BIT]) begin
            calibration_pointer_next[`PTR_LOC_MSB:0] = loc + 6'h01;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            calibration_pointer_reg <= `PTR_RESET;
        end else begin
            calibration_pointer_reg <= calibration_pointer_next;
        end
    end

    // Limit bytes, one register each
    always @(posedge core_clk) begin
        if (!rst_n) begin
            window_greater_than_high_reg <= `LIMIT_RESET;
        end else if (sfr_wr && sfr_addr == `ADDR_WIN_GT_HIGH) begin
            window_greater_than_high_reg <= sfr_wdata;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            window_greater_than_low_reg <= `LIMIT_RESET;
        end else if (sfr_wr && sfr_addr == `ADDR_WIN_GT_LOW) begin
            window_greater_than_low_reg <= sfr_wdata;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            window_less_than_high_reg <= `LIMIT_RESET;
        end else if (sfr_wr && sfr_addr == `ADDR_WIN_LT_HIGH) begin
            window_less_than_high_reg <= sfr_wdata;
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            window_less_than_low_reg <= `LIMIT_RESET;
        end else if (sfr_wr && sfr_addr == `ADDR_WIN_LT_LOW) begin
            window_less_than_low_reg <= sfr_wdata;
        end
    end

    // Window comparison; sign bit flipped so one unsigned compare serves
    always @* begin
        gt_word = {window_greater_than_high_reg,
                   window_greater_than_low_reg};
        lt_word = {window_less_than_high_reg, window_less_than_low_reg};
        res_k = {1'b0, conv0_result[15] ^ diff_mode, conv0_result[14:0]};
        gt_k = {1'b0, gt_word[15] ^ diff_mode, gt_word[14:0]};
        lt_k = {1'b0, lt_word[15] ^ diff_mode, lt_word[14:0]};
        above_gt = res_k > gt_k;
        below_lt = res_k < lt_k;
        if (lt_k > gt_k) begin
            hit = above_gt && below_lt;
        end else begin
            hit = above_gt || below_lt;
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always @* begin
        converter0_control_next = converter0_control_reg;
        if (ctrl_wr) begin
            converter0_control_next = sfr_wdata;
        end
        if (conv0_done && hit) begin
            converter0_control_next[`CTRL_WIN_FLAG_BIT] = 1'b1;
        end
    end

    // Start bits: software sets, finish pulse clears; a new set wins
    always @* begin
        cal_start_next = cal_start_out & ~cal_finished;
        if (start_wr) begin
            cal_start_next = cal_start_next | sfr_wdata[1:0];
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            converter0_control_reg <= `CTRL_RESET;
            window_hit_flag <= 1'b0;
            cal_start_out <= `START_RESET;
        end else begin
            converter0_control_reg <= converter0_control_next;
            window_hit_flag <=
                converter0_control_next[`CTRL_WIN_FLAG_BIT];
            cal_start_out <= cal_start_next;
        end
    end

    // Register read mux
    always @* begin
        rdata_next = 8'h00;
        if (sfr_addr == `ADDR_CAL_POINTER) begin
            rdata_next = calibration_pointer_reg;
        end else if (sfr_addr == `ADDR_WIN_LT_HIGH) begin
            rdata_next = window_less_than_high_reg;
        end else if (sfr_addr == `ADDR_WIN_LT_LOW) begin
            rdata_next = window_less_than_low_reg;
        end else if (sfr_addr == `ADDR_WIN_GT_HIGH) begin
            rdata_next = window_greater_than_high_reg;
        end else if (sfr_addr == `ADDR_WIN_GT_LOW) begin
            rdata_next = window_greater_than_low_reg;
        end else if (sfr_addr == `ADDR_CONV0_CTRL) begin
            rdata_next = converter0_control_reg;
        end else if (sfr_addr == `ADDR_CAL_START) begin
            rdata_next = {6'h00, cal_start_out};
        end
    end

    // Store data arrive a cycle after the strobe, so a coefficient
    // read answers one cycle later than the other registers; a read of
    // another register in the cycle right after it is lost
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rd_data_pending_reg <= 1'b0;
            sfr_rdata <= 8'h00;
        end else begin
            rd_data_pending_reg <= data_rd && loc_valid;
            if (rd_data_pending_reg) begin
                sfr_rdata <= mem_rdata;
            end else if (sfr_rd) begin
                sfr_rdata <= rdata_next;
            end
        end
    end
endmodule

/* bench/adc_cal_window_properties.sv */
// Port-level checker for the calibration and window block
module adc_cal_window_properties (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Register port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    // Events and outputs
    input wire conv0_done,
    input wire [1:0] cal_finished,
    input wire [1:0] cal_start_out,
    input wire [13:0] conv0_offset,
    input wire [12:0] conv0_gain,
    input wire [13:0] conv1_offset,
    input wire [12:0] conv1_gain,
    input wire window_hit_flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire ctrl_wr = sfr_wr && sfr_addr == 8'he8;
    wire data_wr = sfr_wr && sfr_addr == 8'hbb;
    reg done_d1, done_d2, data_wr_d1;
    always @(posedge core_clk) begin
        done_d1 <= conv0_done;
        done_d2 <= done_d1;
        data_wr_d1 <= data_wr;
    end
    wire quiet = !conv0_done && !done_d1 && !done_d2;
    a_flag_holds: assert property (window_hit_flag && !ctrl_wr |=> window_hit_flag) else $error("window flag dropped");
    a_flag_sw_clear: assert property (ctrl_wr && !sfr_wdata[5] && quiet |=> !window_hit_flag) else $error("window flag not cleared");
    a_start0_clears: assert property (cal_start_out[0] && cal_finished[0] && !sfr_wr |=> !cal_start_out[0]) else $error("start 0 not cleared");
    a_start1_clears: assert property (cal_start_out[1] && cal_finished[1] && !sfr_wr |=> !cal_start_out[1]) else $error("start 1 not cleared");
    a_start_holds: assert property (cal_finished == 2'b00 && !sfr_wr |=> $stable(cal_start_out)) else $error("start bits moved");
    a_coef0_stable: assert property (!data_wr && !data_wr_d1 |=> $stable({conv0_offset, conv0_gain})) else $error("conv0 coefficient moved");
    a_coef1_stable: assert property (!data_wr && !data_wr_d1 |=> $stable({conv1_offset, conv1_gain})) else $error("conv1 coefficient moved");
    a_reset_clears: assert property (disable iff (1'b0) !rst_n |=> !window_hit_flag && cal_start_out == 2'b00) else $error("reset values wrong");
    cover property ($rose(window_hit_flag));
    cover property ($fell(cal_start_out[0]));
    cover property (data_wr);
endmodule
bind adc_cal_window adc_cal_window_properties adc_cal_window_properties_inst (.core_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .conv0_done, .cal_finished, .cal_start_out, .conv0_offset, .conv0_gain, .conv1_offset, .conv1_gain, .window_hit_flag);

/* bench/adc_cal_window_tb.sv */
// Self-checking bench for the calibration and window block
module adc_cal_window_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, conv0_done = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    logic [15:0] conv0_result = 16'h0000;
    logic [1:0] cal_finished = 2'b00;
    wire [7:0] sfr_rdata;
    wire [1:0] cal_start_out;
    wire [13:0] conv0_offset, conv1_offset;
    wire [12:0] conv0_gain, conv1_gain;
    wire window_hit_flag;
    int err_total = 0, n_compared = 0;
    adc_cal_window adc_cal_window_inst (.core_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .conv0_done, .conv0_result, .cal_finished, .cal_start_out, .conv0_offset, .conv0_gain, .conv1_offset, .conv1_gain, .window_hit_flag);
    initial forever #25 core_clk = ~core_clk;
    task automatic step(int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Strobe dropped for a cycle so no edge sees two writes merged
    task automatic wr(logic [7:0] a, logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1;
        step(1);
        sfr_wr = 0;
        step(1);
    endtask
    task automatic rchk(string name, logic [7:0] a, logic [7:0] e);
        sfr_addr = a;
        sfr_rd = 1;
        step(1);
        sfr_rd = 0;
        step(2);
        chk(name, e, sfr_rdata);
    endtask
    task automatic conv(logic [15:0] r);
        conv0_result = r;
        conv0_done = 1;
        step(1);
        conv0_done = 0;
        step(3);
    endtask
    task automatic win(logic dif, logic [15:0] lt, logic [15:0] gt,
                       logic [15:0] r, logic exp);
        wr(8'he8, {7'h00, dif});
        wr(8'hc7, lt[15:8]);
        wr(8'hc6, lt[7:0]);
        wr(8'hc5, gt[15:8]);
        wr(8'hc4, gt[7:0]);
        conv(r);
        chk("window_hit_flag", exp, window_hit_flag);
        rchk("converter0_control", 8'he8, {2'b00, exp, 4'h0, dif});
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        step(16);
        rst_n = 1;
        step(1);
        chk("cal_start_out", 2'b00, cal_start_out);
        rchk("calibration_pointer", 8'hba, 8'hd7);
        rchk("window_less_than_high", 8'hc7, 8'h00);
        rchk("window_less_than_low", 8'hc6, 8'h00);
        $display("test reset done");
        wr(8'hba, 8'h13);
        wr(8'hbb, 8'h34);
        wr(8'hba, 8'h14);
        wr(8'hbb, 8'h12);
        chk("conv0_offset", 16'h1234, conv0_offset);
        wr(8'hba, 8'h95);
        wr(8'hbb, 8'hab);
        wr(8'hbb, 8'h1c);
        chk("conv0_gain", 16'h1cab, conv0_gain);
        rchk("calibration_pointer", 8'hba, 8'h97);
        wr(8'hba, 8'hd3);
        wr(8'hbb, 8'h00);
        wr(8'hbb, 8'h20);
        chk("conv1_offset", 16'h2000, conv1_offset);
        chk("conv0_offset", 16'h1234, conv0_offset);
        wr(8'hbb, 8'h34);
        wr(8'hbb, 8'h0f);
        chk("conv1_gain", 16'h0f34, conv1_gain);
        chk("conv0_gain", 16'h1cab, conv0_gain);
        wr(8'hba, 8'h93);
        rchk("coefficient_data", 8'hbb, 8'h34);
        rchk("coefficient_data", 8'hbb, 8'h12);
        rchk("calibration_pointer", 8'hba, 8'h95);
        wr(8'hba, 8'h54);
        rchk("coefficient_data", 8'hbb, 8'h20);
        rchk("coefficient_data", 8'hbb, 8'h20);
        rchk("calibration_pointer", 8'hba, 8'h54);
        wr(8'hba, 8'h00);
        wr(8'hbb, 8'h5a);
        wr(8'hba, 8'h40);
        wr(8'hbb, 8'ha5);
        wr(8'hba, 8'h00);
        rchk("coefficient_data", 8'hbb, 8'h5a);
        $display("test coefficients done");
        win(0, 16'h2000, 16'h1000, 16'h1800, 1);
        win(0, 16'h2000, 16'h1000, 16'h2000, 0);
        win(0, 16'h2000, 16'h1000, 16'h1000, 0);
        win(0, 16'h1000, 16'h2000, 16'h2001, 1);
        win(0, 16'h1000, 16'h2000, 16'h1800, 0);
        win(0, 16'h1000, 16'h2000, 16'h0fff, 1);
        conv(16'h1800);
        chk("window_hit_flag", 1, window_hit_flag);
        win(1, 16'h1000, 16'hffff, 16'h0000, 1);
        win(1, 16'h1000, 16'hffff, 16'hffff, 0);
        win(1, 16'hffff, 16'h1000, 16'hfffe, 1);
        win(1, 16'hffff, 16'h1000, 16'h0800, 0);
        $display("test window done");
        wr(8'hbc, 8'h03);
        chk("cal_start_out", 2'b11, cal_start_out);
        cal_finished = 2'b01;
        step(1);
        cal_finished = 2'b00;
        step(1);
        chk("cal_start_out", 2'b10, cal_start_out);
        cal_finished = 2'b10;
        step(1);
        cal_finished = 2'b00;
        step(1);
        chk("cal_start_out", 2'b00, cal_start_out);
        $display("test calibration start done");
        give_verdict();
    end
    initial begin
        #2000000;
        err_total++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule
